// >>> sat_pkg.sv
// constants, carriers and states of the sector address translator
// assumes a single controller clock; no package imports, every use is scoped
package sat_pkg;

    localparam int CYL_W = 10;
    localparam int HEAD_W = 4;
    localparam int SEC_W = 6;
    localparam int REC_W = 20;

    // first cylinder that logical records may occupy
    localparam logic [CYL_W-1:0] FLOPPY_BASE_CYL = 10'h001;
    localparam logic [CYL_W-1:0] WINCH_BASE_CYL = 10'h000;
    // physical sectors number from one, cylinders and heads from zero
    localparam logic [SEC_W-1:0] SEC_FIRST = 6'h01;
    localparam logic [REC_W-1:0] REC_NONE = 20'h00000;
    localparam logic [SEC_W-1:0] ILV_NONE = 6'h01;

    typedef struct packed {
        logic [CYL_W-1:0] cyl;
        logic [HEAD_W-1:0] head;
        logic [SEC_W-1:0] sec;
    } sat_chs_s;

    typedef struct packed {
        logic logical;
        logic winch;
        logic [REC_W-1:0] rec;
        sat_chs_s chs;
    } sat_req_s;

    typedef struct packed {
        logic [SEC_W-1:0] spt;
        logic [HEAD_W-1:0] heads;
        logic [HEAD_W-1:0] fh_heads;
        logic [CYL_W-1:0] cyls;
        logic [SEC_W-1:0] ilv;
        logic [SEC_W-1:0] off;
        logic log_off_en;
    } sat_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WALK = 2'b01,
        ST_WAIT = 2'b11,
        ST_FIN = 2'b10
    } sat_state_e;

    localparam sat_chs_s CHS_RST = '0;
    localparam sat_req_s REQ_RST = '0;
    localparam sat_cfg_s CFG_RST = '0;

endpackage

// >>> sat_translator.sv
// sector address translator: host record or position in, drive position out
// assumes flaw_hit_i is answered combinationally by same-clock logic
// for the position on flaw_pos_o, and winch_ready_i comes from the drive pin
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - cylinders and heads count from zero, sectors from one.
// - one cylinder holds sectors per track times heads, all equal size.
// - floppy logical record one sits at cylinder 1, head 0, sector 1.
// - flawless Winchester logical record one sits at cylinder 0, head 0, sector 1.
// - flawed Winchester sectors are skipped by logical addressing.
// - record K+1 is always the sequential successor of record K.
// - floppy cylinder 0 is reachable by physical addressing only.
// - logical addressing covers moving heads only; fixed heads need physical.
// - with offset and interleave, skip the larger of the two, not the sum.
// - a physical interleave factor may be chosen for floppy or fixed disk.
// - floppy offset is physical at format or logical per transfer, host picks.
// - consecutive sectors transfer with no interleave needed.
// - cylinder offset shifts the first sector of each next cylinder.
// - no Winchester access starts until the drive reports at speed.
module sat_translator (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire sat_pkg::sat_req_s req_i,
    input wire sat_pkg::sat_cfg_s cfg_i,
    input wire logic winch_ready_i,
    input wire logic flaw_hit_i,
    output logic busy_o,
    output logic flaw_chk_o,
    output sat_pkg::sat_chs_s flaw_pos_o,
    output logic start_o,
    output sat_pkg::sat_chs_s pos_o,
    output logic pos_winch_o,
    output logic done_o,
    output logic err_o
);

    // sum of two in-range sector indices folded back into 0..m-1
    function automatic logic [sat_pkg::SEC_W-1:0] wrap_add(
        input logic [sat_pkg::SEC_W-1:0] a,
        input logic [sat_pkg::SEC_W-1:0] b,
        input logic [sat_pkg::SEC_W-1:0] m
    );
        logic [sat_pkg::SEC_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, m}) begin
            s = s - {1'b0, m};
        end
        return s[sat_pkg::SEC_W-1:0];
    endfunction

    function automatic logic [sat_pkg::SEC_W-1:0] max_sec(
        input logic [sat_pkg::SEC_W-1:0] a,
        input logic [sat_pkg::SEC_W-1:0] b
    );
        return (a > b) ? a : b;
    endfunction

    // ready pin synchroniser; only the second stage is read
    logic rdy_s1_q;
    logic rdy_s2_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
        end else if (ce_i) begin
            rdy_s1_q <= winch_ready_i;
            rdy_s2_q <= rdy_s1_q;
        end
    end

    // translation state
    sat_pkg::sat_state_e state_q, state_d;
    sat_pkg::sat_req_s req_q, req_d;
    sat_pkg::sat_cfg_s cfg_q, cfg_d;
    logic [sat_pkg::CYL_W-1:0] cyl_q, cyl_d;
    logic [sat_pkg::HEAD_W-1:0] head_q, head_d;
    logic [sat_pkg::SEC_W-1:0] p_q, p_d;
    logic [sat_pkg::SEC_W-1:0] ts_q, ts_d;
    logic [sat_pkg::SEC_W-1:0] rs_q, rs_d;
    logic [sat_pkg::SEC_W-1:0] slot_q, slot_d;
    logic [sat_pkg::REC_W-1:0] cnt_q, cnt_d;
    logic fail_q, fail_d;
    logic busy_q, busy_d;
    logic chk_q, chk_d;
    sat_pkg::sat_chs_s fpos_q, fpos_d;
    logic start_q, start_d;
    sat_pkg::sat_chs_s pos_q, pos_d;
    logic pwinch_q, pwinch_d;
    logic done_q, done_d;
    logic err_q, err_d;

    // derived step sizes of the captured configuration, plus the physical head check on the live ports
    logic [sat_pkg::SEC_W-1:0] ilv_eff;
    logic [sat_pkg::SEC_W-1:0] off_eff;
    logic [sat_pkg::SEC_W-1:0] skew;
    logic head_lim;
    logic [sat_pkg::SEC_W-1:0] np;
    logic [sat_pkg::REC_W-1:0] cnt_inc;
    logic hit;

    always_comb begin
        // zero interleave is read as none, so consecutive sectors
        ilv_eff = (cfg_q.ilv == '0) ? sat_pkg::ILV_NONE : cfg_q.ilv;
        // format-time offset is already on the medium; only logical is applied
        off_eff = cfg_q.log_off_en ? cfg_q.off : '0;
        // skew per cylinder is the larger of offset and interleave gap
        skew = max_sec(off_eff, ilv_eff - sat_pkg::ILV_NONE);
        // physical heads include the fixed-head set only on a Winchester
        head_lim = {1'b0, req_i.chs.head} < ({1'b0, cfg_i.heads} +
                   (req_i.winch ? {1'b0, cfg_i.fh_heads} : '0)) ? 1'b1 : 1'b0;
        np = wrap_add(p_q, ilv_eff, cfg_q.spt);
        cnt_inc = cnt_q + 20'h00001;
        // floppies carry no flaw map
        hit = req_q.winch & flaw_hit_i;
    end

    // next-state logic of the walk and handshake
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        cfg_d = cfg_q;
        cyl_d = cyl_q;
        head_d = head_q;
        p_d = p_q;
        ts_d = ts_q;
        rs_d = rs_q;
        slot_d = slot_q;
        cnt_d = cnt_q;
        fail_d = fail_q;
        busy_d = busy_q;
        pos_d = pos_q;
        pwinch_d = pwinch_q;
        start_d = 1'b0;
        done_d = 1'b0;
        err_d = 1'b0;
        case (state_q)
            sat_pkg::ST_IDLE: begin
                if (req_valid_i) begin
                    req_d = req_i;
                    cfg_d = cfg_i;
                    busy_d = 1'b1;
                    fail_d = 1'b0;
                    pwinch_d = req_i.winch;
                    if (req_i.logical) begin
                        // floppy logical space starts past cylinder 0
                        cyl_d = req_i.winch ? sat_pkg::WINCH_BASE_CYL
                                            : sat_pkg::FLOPPY_BASE_CYL;
                        head_d = '0;
                        p_d = '0;
                        ts_d = '0;
                        rs_d = '0;
                        slot_d = '0;
                        cnt_d = sat_pkg::REC_NONE;
                        if (req_i.rec == sat_pkg::REC_NONE) begin
                            fail_d = 1'b1;
                            state_d = sat_pkg::ST_FIN;
                        end else if (cyl_d >= cfg_i.cyls || cfg_i.spt == '0 ||
                                     cfg_i.heads == '0) begin
                            fail_d = 1'b1;
                            state_d = sat_pkg::ST_FIN;
                        end else begin
                            state_d = sat_pkg::ST_WALK;
                        end
                    end else begin
                        // physical positions are range checked, cylinder 0 allowed
                        if (req_i.chs.sec >= sat_pkg::SEC_FIRST &&
                            req_i.chs.sec <= cfg_i.spt && head_lim &&
                            req_i.chs.cyl < cfg_i.cyls) begin
                            pos_d = req_i.chs;
                            state_d = sat_pkg::ST_WAIT;
                        end else begin
                            fail_d = 1'b1;
                            state_d = sat_pkg::ST_FIN;
                        end
                    end
                end
            end
            sat_pkg::ST_WALK: begin
                // one physical sector examined per cycle, in logical order
                if (!hit) begin
                    cnt_d = cnt_inc;
                end
                if (!hit && cnt_inc == req_q.rec) begin
                    pos_d.cyl = cyl_q;
                    pos_d.head = head_q;
                    pos_d.sec = p_q + sat_pkg::SEC_FIRST;
                    state_d = sat_pkg::ST_WAIT;
                end else if (slot_q + 6'h01 == cfg_q.spt) begin
                    // track done: next moving head, then next cylinder
                    slot_d = '0;
                    if (head_q + 4'h1 == cfg_q.heads) begin
                        head_d = '0;
                        if (cyl_q + 10'h001 == cfg_q.cyls) begin
                            fail_d = 1'b1;
                            state_d = sat_pkg::ST_FIN;
                        end else begin
                            cyl_d = cyl_q + 10'h001;
                            // shift first sector so it arrives after the step
                            ts_d = wrap_add(ts_q, skew, cfg_q.spt);
                            p_d = ts_d;
                            rs_d = ts_d;
                        end
                    end else begin
                        head_d = head_q + 4'h1;
                        p_d = ts_q;
                        rs_d = ts_q;
                    end
                end else begin
                    // interleave stride; a revisit moves the pass on by one
                    slot_d = slot_q + 6'h01;
                    if (np == rs_q) begin
                        p_d = wrap_add(rs_q, sat_pkg::ILV_NONE, cfg_q.spt);
                        rs_d = p_d;
                    end else begin
                        p_d = np;
                    end
                end
            end
            sat_pkg::ST_WAIT: begin
                // floppies need no spin-up gate
                if (!req_q.winch || rdy_s2_q) begin
                    start_d = 1'b1;
                    state_d = sat_pkg::ST_FIN;
                end
            end
            sat_pkg::ST_FIN: begin
                done_d = 1'b1;
                err_d = fail_q;
                busy_d = 1'b0;
                state_d = sat_pkg::ST_IDLE;
            end
            default: begin
                state_d = sat_pkg::ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
        // flaw lookup address follows the walk position one-based
        chk_d = (state_d == sat_pkg::ST_WALK) && req_d.winch;
        fpos_d.cyl = cyl_d;
        fpos_d.head = head_d;
        fpos_d.sec = p_d + sat_pkg::SEC_FIRST;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= sat_pkg::ST_IDLE;
            req_q <= sat_pkg::REQ_RST;
            cfg_q <= sat_pkg::CFG_RST;
            cyl_q <= '0;
            head_q <= '0;
            p_q <= '0;
            ts_q <= '0;
            rs_q <= '0;
            slot_q <= '0;
            cnt_q <= '0;
            fail_q <= 1'b0;
            busy_q <= 1'b0;
            chk_q <= 1'b0;
            fpos_q <= sat_pkg::CHS_RST;
            start_q <= 1'b0;
            pos_q <= sat_pkg::CHS_RST;
            pwinch_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            req_q <= req_d;
            cfg_q <= cfg_d;
            cyl_q <= cyl_d;
            head_q <= head_d;
            p_q <= p_d;
            ts_q <= ts_d;
            rs_q <= rs_d;
            slot_q <= slot_d;
            cnt_q <= cnt_d;
            fail_q <= fail_d;
            busy_q <= busy_d;
            chk_q <= chk_d;
            fpos_q <= fpos_d;
            start_q <= start_d;
            pos_q <= pos_d;
            pwinch_q <= pwinch_d;
            done_q <= done_d;
            err_q <= err_d;
        end
    end

    // all outputs straight from flops
    assign busy_o = busy_q;
    assign flaw_chk_o = chk_q;
    assign flaw_pos_o = fpos_q;
    assign start_o = start_q;
    assign pos_o = pos_q;
    assign pos_winch_o = pwinch_q;
    assign done_o = done_q;
    assign err_o = err_q;

endmodule

`default_nettype wire

// >>> sat_drive_model.sv
// drive side stand-in: at-speed pin after a spin-up count, one flawed sector
// assumes flaw_pos_i is the translator's registered walk position
`timescale 1ns/100ps
`default_nettype none
module sat_drive_model #(
    parameter int SPIN = 30
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_i,
    input wire logic flaw_en_i,
    input wire sat_pkg::sat_chs_s flaw_pos_i,
    output logic ready_o,
    output logic flaw_o
);
    localparam sat_pkg::sat_chs_s FLAW = '{10'h000, 4'h0, 6'h01};
    int cnt_q;
    // spin-up count restarts whenever power drops, like a cold start
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 0;
        end else if (!power_i) begin
            cnt_q <= 0;
        end else if (cnt_q < SPIN) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign ready_o = (cnt_q == SPIN);
    // flaw lookup answers in the same cycle, as the walk needs
    assign flaw_o = flaw_en_i && (flaw_pos_i == FLAW);
endmodule
`default_nettype wire

// >>> sat_translator_properties.sv
// port checker for the sector address translator
// assumes it is bound into every sat_translator instance
`timescale 1ns/100ps
`default_nettype none
module sat_translator_properties (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire sat_pkg::sat_req_s req_i,
    input wire sat_pkg::sat_cfg_s cfg_i,
    input wire logic winch_ready_i,
    input wire logic flaw_hit_i,
    input wire logic busy_o,
    input wire logic flaw_chk_o,
    input wire sat_pkg::sat_chs_s flaw_pos_o,
    input wire logic start_o,
    input wire sat_pkg::sat_chs_s pos_o,
    input wire logic pos_winch_o,
    input wire logic done_o,
    input wire logic err_o
);
    logic take;
    sat_pkg::sat_req_s req_q, req_d;
    sat_pkg::sat_cfg_s cfg_q, cfg_d;
    assign take = ce_i && req_valid_i && !busy_o;
    // keep the accepted request; the ports may move on during the walk
    always_comb begin
        req_d = take ? req_i : req_q;
        cfg_d = take ? cfg_i : cfg_q;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= '0;
            cfg_q <= '0;
        end else begin
            req_q <= req_d;
            cfg_q <= cfg_d;
        end
    end
    default clocking dck @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_phys;
        take && !req_i.logical && !req_i.winch;
    endsequence
    sequence s_phys_end;
        (start_o && !err_o ##1 done_o && !err_o) or (done_o && err_o && !start_o);
    endsequence
    // a flawed probe moves the walk on, or the walk runs off the disk and is refused
    sequence s_flaw_step;
        ##1 flaw_chk_o && flaw_pos_o != $past(flaw_pos_o);
    endsequence
    sequence s_flaw_end;
        ##2 done_o && err_o;
    endsequence
    phys_timing_a: assert property (s_phys |-> ##2 s_phys_end)
        else $error("physical request answer out of step");
    refuse_quiet_a: assert property (
        err_o |-> done_o && !start_o && !$past(start_o))
        else $error("refused request touched the drive");
    start_done_a: assert property (start_o |=> done_o && !err_o)
        else $error("access start not followed by done");
    // pin to start is two synchroniser stages plus the start flop
    ready_gate_a: assert property (
        start_o && pos_winch_o |-> $past(winch_ready_i, 3))
        else $error("fixed disk access before at speed");
    sector_base_a: assert property (start_o |-> pos_o.sec != 6'h00)
        else $error("sector zero issued");
    floppy_cyl0_a: assert property (
        start_o && !pos_winch_o && req_q.logical |-> pos_o.cyl != 10'h000)
        else $error("logical floppy reached cylinder zero");
    moving_head_a: assert property (
        start_o && pos_winch_o && req_q.logical |-> pos_o.head < cfg_q.heads)
        else $error("logical access on a fixed head");
    flaw_scope_a: assert property (
        flaw_chk_o |-> busy_o && req_q.winch && req_q.logical)
        else $error("flaw probe outside a fixed disk walk");
    flaw_skip_a: assert property (
        flaw_chk_o && flaw_hit_i |-> s_flaw_step or s_flaw_end)
        else $error("flawed sector not stepped over");
    accept_busy_a: assert property (take |=> busy_o && !start_o)
        else $error("request not taken or started early");
endmodule
bind sat_translator sat_translator_properties u_props (
    .clk_i, .rst_n_i, .ce_i, .req_valid_i, .req_i, .cfg_i, .winch_ready_i, .flaw_hit_i,
    .busy_o, .flaw_chk_o, .flaw_pos_o, .start_o, .pos_o, .pos_winch_o, .done_o, .err_o
);
`default_nettype wire

// >>> tb.sv
// self-checking bench for the sector address translator
// assumes the drive model and the bound checker are compiled with it
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin cmp_count++; if ((g) !== (w)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, g, w); end end
module tb;
    logic clk_i, rst_n_i, ce_i, req_valid_i, winch_ready_i, flaw_hit_i, busy_o, flaw_chk_o;
    logic start_o, pos_winch_o, done_o, err_o, power, flaw_en, started;
    sat_pkg::sat_req_s req_i;
    sat_pkg::sat_cfg_s cfg_i;
    sat_pkg::sat_chs_s flaw_pos_o, pos_o;
    int bad_count, cmp_count;
    int seed = 76;
    logic [21:0] exp_q[$];
    logic [21:0] e;
    sat_translator dut (.clk_i, .rst_n_i, .ce_i, .req_valid_i, .req_i, .cfg_i, .winch_ready_i,
        .flaw_hit_i, .busy_o, .flaw_chk_o, .flaw_pos_o, .start_o, .pos_o, .pos_winch_o, .done_o,
        .err_o);
    sat_drive_model #(.SPIN(30)) u_drive (.clk_i, .rst_n_i, .power_i(power),
        .flaw_en_i(flaw_en), .flaw_pos_i(flaw_pos_o), .ready_o(winch_ready_i), .flaw_o(flaw_hit_i));
    function automatic sat_pkg::sat_chs_s p(input int c, input int h, input int s);
        p = '{c[9:0], h[3:0], s[5:0]};
    endfunction
    task automatic conclude;
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one request, expectation noted first; waits for the answer under a bound
    task automatic go(input int lg, input int wn, input int rec, input sat_pkg::sat_chs_s chs,
            input int er, input sat_pkg::sat_chs_s x);
        int n;
        exp_q.push_back({er[0], wn[0], x});
        req_i = '{lg[0], wn[0], rec[19:0], chs};
        req_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        for (n = 0; n < 300 && busy_o !== 1'b0; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (n == 300) begin
            bad_count++;
            conclude();
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // result watcher: each done answers the oldest note
    always @(posedge clk_i) begin
        if (start_o === 1'b1) started = 1'b1;
        if (done_o === 1'b1) begin
            `CHK(exp_q.size() != 0, 1'b1)
            e = exp_q.pop_front();
            `CHK(err_o, e[21])
            `CHK(started, !e[21])
            if (!e[21]) `CHK(pos_o, e[19:0])
            `CHK(pos_winch_o, e[20])
            started = 1'b0;
        end
    end
    initial begin
        int i, c, h, s;
        {rst_n_i, req_valid_i, flaw_en, started, bad_count, cmp_count} = '0;
        {ce_i, power} = 2'b11;
        req_i = '0;
        cfg_i = '{6'h1a, 4'h2, 4'h0, 10'h04d, 6'h01, 6'h00, 1'b0};
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        // frozen clock enable: a held strobe is not taken
        ce_i = 1'b0;
        req_valid_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        `CHK(busy_o, 1'b0)
        // drop the strobe and let an edge pass before the first real request
        {ce_i, req_valid_i} = 2'b10;
        @(posedge clk_i);
        #1;
        go(0, 0, 0, p(0, 0, 3), 0, p(0, 0, 3));
        go(0, 0, 0, p(5, 1, 0), 1, p(0, 0, 0));
        go(0, 0, 0, p(5, 1, 27), 1, p(0, 0, 0));
        go(0, 0, 0, p(5, 2, 1), 1, p(0, 0, 0));
        go(1, 0, 1, p(0, 0, 0), 0, p(1, 0, 1));
        go(1, 0, 27, p(0, 0, 0), 0, p(1, 1, 1));
        go(1, 0, 53, p(0, 0, 0), 0, p(2, 0, 1));
        go(1, 0, 0, p(0, 0, 0), 1, p(0, 0, 0));
        for (i = 0; i < 8; i++) begin
            c = $unsigned($random(seed)) % 77;
            h = $unsigned($random(seed)) % 2;
            s = $unsigned($random(seed)) % 26 + 1;
            go(0, 0, 0, p(c, h, s), 0, p(c, h, s));
        end
        cfg_i.cyls = 10'h003;
        go(1, 0, 104, p(0, 0, 0), 0, p(2, 1, 26));
        go(1, 0, 105, p(0, 0, 0), 1, p(0, 0, 0));
        // fixed disk spun down: the request must wait for at speed
        cfg_i = '{6'h08, 4'h2, 4'h1, 10'h00a, 6'h01, 6'h00, 1'b0};
        power = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        fork
            go(1, 1, 1, p(0, 0, 0), 0, p(0, 0, 1));
            begin
                repeat (20) @(posedge clk_i);
                #1;
                `CHK(busy_o, 1'b1)
                power = 1'b1;
            end
        join
        go(0, 1, 0, p(3, 2, 5), 0, p(3, 2, 5));
        go(0, 1, 0, p(3, 3, 5), 1, p(0, 0, 0));
        go(1, 1, 17, p(0, 0, 0), 0, p(1, 0, 1));
        flaw_en = 1'b1;
        go(1, 1, 1, p(0, 0, 0), 0, p(0, 0, 2));
        go(1, 1, 2, p(0, 0, 0), 0, p(0, 0, 3));
        flaw_en = 1'b0;
        // interleave of two: logical records stride across the track, then a second pass
        cfg_i.ilv = 6'h02;
        go(1, 1, 2, p(0, 0, 0), 0, p(0, 0, 3));
        go(1, 1, 5, p(0, 0, 0), 0, p(0, 0, 2));
        // cylinder skew: larger of offset and interleave, never the sum
        cfg_i = '{6'h08, 4'h1, 4'h0, 10'h00a, 6'h01, 6'h03, 1'b1};
        go(1, 1, 9, p(0, 0, 0), 0, p(1, 0, 4));
        cfg_i.ilv = 6'h02;
        go(1, 1, 9, p(0, 0, 0), 0, p(1, 0, 4));
        cfg_i = '{6'h08, 4'h1, 4'h0, 10'h00a, 6'h01, 6'h03, 1'b0};
        go(1, 1, 9, p(0, 0, 0), 0, p(1, 0, 1));
        repeat (2) @(posedge clk_i);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule
`default_nettype wire
